/* logic/dbg_sel_pkg.sv */
// Constants and carrier types for the debug and boundary-scan port selector
package dbg_sel_pkg;

  localparam int unsigned BREAKPOINTS   = 4;
  localparam int unsigned WATCHPOINTS   = 2;
  localparam int unsigned POWERUP_WAIT_US = 250;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned POWERUP_CYCLES = POWERUP_WAIT_US * CLK_MHZ;
  localparam logic [3:0]  IR_BYPASS     = 4'hF;
  localparam logic [3:0]  IR_EXTEST     = 4'h0;
  localparam logic [3:0]  IR_SAMPLE     = 4'h1;
  localparam logic [3:0]  IR_IDCODE     = 4'h2;
  localparam logic [31:0] ID_CODE       = 32'h0000_1001;  // Arbitrary value

  typedef enum logic [1:0] {
    MODE_HALT = 2'h0,
    MODE_SCAN = 2'h1,
    MODE_DEBUG = 2'h2
  } mode_type;

  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SH_DR   = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PA_DR   = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UP_DR   = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'hA,
    TAP_SH_IR   = 4'hB,
    TAP_EX1_IR  = 4'hC,
    TAP_PA_IR   = 4'hD,
    TAP_EX2_IR  = 4'hE,
    TAP_UP_IR   = 4'hF
  } tap_state_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } scan_pins_type;

  typedef struct packed {
    logic swclk;
    logic swdio;
  } swd_pins_type;

endpackage

/* logic/dbg_sel.sv */
// Debug and boundary-scan port selector with scan tap
`timescale 1ns/1ps
`default_nettype none
module dbg_sel #(
  parameter int unsigned BSR_LEN = 8,
  parameter int unsigned BP_NUM  = dbg_sel_pkg::BREAKPOINTS,
  parameter int unsigned WP_NUM  = dbg_sel_pkg::WATCHPOINTS
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       reset_n_pin,
  input  wire dbg_sel_pkg::scan_pins_type scan_in,
  input  wire dbg_sel_pkg::swd_pins_type  swd_in,
  input  wire logic [BSR_LEN-1:0]         pin_in,
  input  wire logic [BSR_LEN-1:0]         core_out,
  output logic                            tdo,
  output logic                            tdo_oe,
  output logic                            scan_mode,
  output logic                            swd_enable,
  output logic                            chip_in_reset,
  output logic [BSR_LEN-1:0]              pin_out,
  output logic [BSR_LEN-1:0]              pin_oe_scan,
  output logic                            swdclk_core,
  output logic                            swdio_core,
  output logic [2:0]                      bp_count,
  output logic [1:0]                      wp_count
);

  logic [1:0] rst_sync_q;
  logic [2:0] tck_sync_q;
  logic [1:0] tms_sync_q;
  logic [1:0] tdi_sync_q;
  logic [1:0] trst_sync_q;
  logic [1:0] swclk_sync_q;
  logic [1:0] swdio_sync_q;
  logic [BSR_LEN-1:0] pin_sync1_q;
  logic [BSR_LEN-1:0] pin_sync2_q;

  // Two-stage synchronisers for all pins
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_sync_q   <= 2'h0;
      tck_sync_q   <= 3'h0;
      tms_sync_q   <= 2'h3;
      tdi_sync_q   <= 2'h0;
      trst_sync_q  <= 2'h0;
      swclk_sync_q <= 2'h0;
      swdio_sync_q <= 2'h0;
      pin_sync1_q  <= '0;
      pin_sync2_q  <= '0;
    end else begin
      rst_sync_q   <= {rst_sync_q[0], reset_n_pin};
      tck_sync_q   <= {tck_sync_q[1:0], scan_in.tck};
      tms_sync_q   <= {tms_sync_q[0], scan_in.tms};
      tdi_sync_q   <= {tdi_sync_q[0], scan_in.tdi};
      trst_sync_q  <= {trst_sync_q[0], scan_in.trst_n};
      swclk_sync_q <= {swclk_sync_q[0], swd_in.swclk};
      swdio_sync_q <= {swdio_sync_q[0], swd_in.swdio};
      pin_sync1_q  <= pin_in;
      pin_sync2_q  <= pin_sync1_q;
    end
  end

  logic rst_pin_lvl;
  logic trst_act;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  assign rst_pin_lvl = rst_sync_q[1];
  assign trst_act    = ~trst_sync_q[1];
  assign tck_rise    = tck_sync_q[1] & ~tck_sync_q[2];
  assign tck_fall    = ~tck_sync_q[1] & tck_sync_q[2];
  assign tms_s       = tms_sync_q[1];
  assign tdi_s       = tdi_sync_q[1];

  dbg_sel_pkg::mode_type mode_q, mode_d;

  always_comb begin
    mode_d = mode_q;
    if (!rst_pin_lvl) begin
      mode_d = dbg_sel_pkg::MODE_SCAN;
    end else begin
      mode_d = dbg_sel_pkg::MODE_DEBUG;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= dbg_sel_pkg::MODE_HALT;
    end else begin
      mode_q <= mode_d;
    end
  end

  logic scan_act;
  assign scan_act = (mode_q == dbg_sel_pkg::MODE_SCAN);

  dbg_sel_pkg::tap_state_type tap_q, tap_d;
  logic [3:0]         ir_q, ir_d;
  logic [3:0]         irsh_q, irsh_d;
  logic [31:0]        dr_q, dr_d;
  logic [BSR_LEN-1:0] bsr_q, bsr_d;
  logic [BSR_LEN-1:0] upd_q, upd_d;
  logic               tdo_q, tdo_d;
  logic               tdo_oe_q, tdo_oe_d;
  logic               bsr_sel;

  assign bsr_sel = (ir_q == dbg_sel_pkg::IR_EXTEST) | (ir_q == dbg_sel_pkg::IR_SAMPLE);

  always_comb begin
    tap_d    = tap_q;
    ir_d     = ir_q;
    irsh_d   = irsh_q;
    dr_d     = dr_q;
    bsr_d    = bsr_q;
    upd_d    = upd_q;
    tdo_d    = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (trst_act || !scan_act) begin
      tap_d    = dbg_sel_pkg::TAP_RESET;
      ir_d     = dbg_sel_pkg::IR_IDCODE;
      tdo_oe_d = 1'b0;
    end else if (tck_rise) begin
      unique case (tap_q)
        dbg_sel_pkg::TAP_RESET:  tap_d = tms_s ? dbg_sel_pkg::TAP_RESET : dbg_sel_pkg::TAP_IDLE;
        dbg_sel_pkg::TAP_IDLE:   tap_d = tms_s ? dbg_sel_pkg::TAP_SEL_DR : dbg_sel_pkg::TAP_IDLE;
        dbg_sel_pkg::TAP_SEL_DR: tap_d = tms_s ? dbg_sel_pkg::TAP_SEL_IR : dbg_sel_pkg::TAP_CAP_DR;
        dbg_sel_pkg::TAP_CAP_DR: begin
          tap_d = tms_s ? dbg_sel_pkg::TAP_EX1_DR : dbg_sel_pkg::TAP_SH_DR;
          dr_d  = (ir_q == dbg_sel_pkg::IR_IDCODE) ? dbg_sel_pkg::ID_CODE : 32'h0000_0000;
          bsr_d = pin_sync2_q;
        end
        dbg_sel_pkg::TAP_SH_DR: begin
          tap_d = tms_s ? dbg_sel_pkg::TAP_EX1_DR : dbg_sel_pkg::TAP_SH_DR;
          if (bsr_sel) begin
            bsr_d = {tdi_s, bsr_q[BSR_LEN-1:1]};
          end else if (ir_q == dbg_sel_pkg::IR_IDCODE) begin
            dr_d = {tdi_s, dr_q[31:1]};
          end else begin
            dr_d = {31'h0000_0000, tdi_s};
          end
        end
        dbg_sel_pkg::TAP_EX1_DR: tap_d = tms_s ? dbg_sel_pkg::TAP_UP_DR : dbg_sel_pkg::TAP_PA_DR;
        dbg_sel_pkg::TAP_PA_DR:  tap_d = tms_s ? dbg_sel_pkg::TAP_EX2_DR : dbg_sel_pkg::TAP_PA_DR;
        dbg_sel_pkg::TAP_EX2_DR: tap_d = tms_s ? dbg_sel_pkg::TAP_UP_DR : dbg_sel_pkg::TAP_SH_DR;
        dbg_sel_pkg::TAP_UP_DR: begin
          tap_d = tms_s ? dbg_sel_pkg::TAP_SEL_DR : dbg_sel_pkg::TAP_IDLE;
          if (bsr_sel) begin
            upd_d = bsr_q;
          end
        end
        dbg_sel_pkg::TAP_SEL_IR: tap_d = tms_s ? dbg_sel_pkg::TAP_RESET : dbg_sel_pkg::TAP_CAP_IR;
        dbg_sel_pkg::TAP_CAP_IR: begin
          tap_d  = tms_s ? dbg_sel_pkg::TAP_EX1_IR : dbg_sel_pkg::TAP_SH_IR;
          irsh_d = 4'h1;
        end
        dbg_sel_pkg::TAP_SH_IR: begin
          tap_d  = tms_s ? dbg_sel_pkg::TAP_EX1_IR : dbg_sel_pkg::TAP_SH_IR;
          irsh_d = {tdi_s, irsh_q[3:1]};
        end
        dbg_sel_pkg::TAP_EX1_IR: tap_d = tms_s ? dbg_sel_pkg::TAP_UP_IR : dbg_sel_pkg::TAP_PA_IR;
        dbg_sel_pkg::TAP_PA_IR:  tap_d = tms_s ? dbg_sel_pkg::TAP_EX2_IR : dbg_sel_pkg::TAP_PA_IR;
        dbg_sel_pkg::TAP_EX2_IR: tap_d = tms_s ? dbg_sel_pkg::TAP_UP_IR : dbg_sel_pkg::TAP_SH_IR;
        dbg_sel_pkg::TAP_UP_IR: begin
          tap_d = tms_s ? dbg_sel_pkg::TAP_SEL_DR : dbg_sel_pkg::TAP_IDLE;
          ir_d  = irsh_q;
        end
      endcase
    end else if (tck_fall) begin
      tdo_oe_d = (tap_q == dbg_sel_pkg::TAP_SH_DR) | (tap_q == dbg_sel_pkg::TAP_SH_IR);
      if (tap_q == dbg_sel_pkg::TAP_SH_IR) begin
        tdo_d = irsh_q[0];
      end else if (bsr_sel) begin
        tdo_d = bsr_q[0];
      end else begin
        tdo_d = dr_q[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tap_q    <= dbg_sel_pkg::TAP_RESET;
      ir_q     <= dbg_sel_pkg::IR_IDCODE;
      irsh_q   <= 4'h0;
      dr_q     <= 32'h0000_0000;
      bsr_q    <= '0;
      upd_q    <= '0;
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tap_q    <= tap_d;
      ir_q     <= ir_d;
      irsh_q   <= irsh_d;
      dr_q     <= dr_d;
      bsr_q    <= bsr_d;
      upd_q    <= upd_d;
      tdo_q    <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      tdo           <= 1'b0;
      tdo_oe        <= 1'b0;
      scan_mode     <= 1'b0;
      swd_enable    <= 1'b0;
      chip_in_reset <= 1'b1;
      pin_out       <= '0;
      pin_oe_scan   <= '0;
      swdclk_core   <= 1'b0;
      swdio_core    <= 1'b0;
      bp_count      <= 3'h0;
      wp_count      <= 2'h0;
    end else begin
      tdo           <= tdo_q & scan_act;
      tdo_oe        <= tdo_oe_q & scan_act;
      scan_mode     <= (mode_d == dbg_sel_pkg::MODE_SCAN);
      swd_enable    <= (mode_d == dbg_sel_pkg::MODE_DEBUG);
      chip_in_reset <= ~rst_pin_lvl;
      if (scan_act && !trst_act && ir_q == dbg_sel_pkg::IR_EXTEST) begin
        pin_out     <= upd_q;
        pin_oe_scan <= '1;
      end else begin
        pin_out     <= core_out;
        pin_oe_scan <= '0;
      end
      swdclk_core   <= swclk_sync_q[1] & (mode_q == dbg_sel_pkg::MODE_DEBUG);
      swdio_core    <= swdio_sync_q[1] & (mode_q == dbg_sel_pkg::MODE_DEBUG);
      bp_count      <= 3'(BP_NUM);
      wp_count      <= 2'(WP_NUM);
    end
  end

endmodule
`default_nettype wire

/* testbench/dbg_sel_chk.sv */
// Checker for the debug and scan port selector
`timescale 1ns/1ps
`default_nettype none
module dbg_sel_chk (
  input wire logic                       clk,
  input wire logic                       srst,
  input wire logic                       reset_n_pin,
  input wire dbg_sel_pkg::scan_pins_type scan_in,
  input wire dbg_sel_pkg::swd_pins_type  swd_in,
  input wire logic                       tdo_oe,
  input wire logic                       scan_mode,
  input wire logic                       swd_enable,
  input wire logic                       chip_in_reset,
  input wire logic                       swdclk_core,
  input wire logic                       swdio_core,
  input wire logic [2:0]                 bp_count,
  input wire logic [1:0]                 wp_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence pin_low_held;
    !reset_n_pin [*6];
  endsequence
  sequence pin_high_held;
    reset_n_pin [*6];
  endsequence
  a_scan_on_low: assert property (
    pin_low_held |-> scan_mode && !swd_enable) else $error("scan mode missing");
  a_debug_on_high: assert property (
    pin_high_held |-> swd_enable && !scan_mode) else $error("debug mode missing");
  a_reset_flag: assert property (
    pin_low_held |-> chip_in_reset) else $error("reset flag missing");
  a_swd_held_off: assert property (
    chip_in_reset |-> !swd_enable) else $error("debug port on in reset");
  a_swd_gated: assert property (
    scan_mode [*2] |-> !swdclk_core && !swdio_core) else $error("debug pins leak");
  a_swd_passes: assert property (
    (swd_enable && swd_in.swclk) [*5] |-> swdclk_core) else $error("debug clock lost");
  a_tap_held: assert property (
    !scan_in.trst_n [*6] |-> !tdo_oe) else $error("scan out while held");
  a_scan_only: assert property (
    !scan_mode [*6] |-> !tdo_oe) else $error("scan out outside scan mode");
  a_debug_caps: assert property (
    !$past(srst) |-> bp_count == 3'h4 && wp_count == 2'h2) else $error("wrong capabilities");
endmodule
bind dbg_sel dbg_sel_chk chk (.clk, .srst, .reset_n_pin, .scan_in, .swd_in, .tdo_oe,
  .scan_mode, .swd_enable, .chip_in_reset, .swdclk_core, .swdio_core, .bp_count, .wp_count);
`default_nettype wire

/* testbench/scan_tester.sv */
// Scan tester model driving reset and scan pins
`timescale 1ns/1ps
`default_nettype none
module scan_tester (
  input  wire logic                      clk,
  input  wire logic                      tdo,
  output var dbg_sel_pkg::scan_pins_type pins,
  output var logic                       reset_n
);
  initial begin
    pins = 4'b0101;
    reset_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic power_up();
    reset_n = 1'b1;
    #(dbg_sel_pkg::POWERUP_WAIT_US * 1000);
    wait_clk(1);
  endtask
  task automatic set_pins(input logic rst_n, input logic trst_n);
    pins.trst_n = trst_n;
    wait_clk(6);
    reset_n = rst_n;
    wait_clk(6);
  endtask
  // One bit, link clock low between bits
  task automatic tck_bit(input logic tms, input logic tdi, output logic seen);
    pins.tms = tms;
    pins.tdi = tdi;
    wait_clk(10);
    seen = tdo;
    pins.tck = 1'b1;
    wait_clk(10);
    pins.tck = 1'b0;
  endtask
  task automatic shift(input logic [31:0] tms_v, input logic [31:0] tdi_v, input int n,
                       output logic [31:0] got);
    logic b;
    got = '0;
    for (int i = 0; i < n; i++) begin
      tck_bit(tms_v[i], tdi_v[i], b);
      got[i] = b;
    end
  endtask
endmodule
`default_nettype wire

/* testbench/dbg_sel_tb_top.sv */
// Testbench for the debug and scan port selector
`timescale 1ns/1ps
`default_nettype none
module dbg_sel_tb_top;
  typedef struct packed {
    logic       pin;
    logic [1:0] swd;
    logic [2:0] mode;
    logic [1:0] core;
  } row_type;
  logic                       clk = 1'b0;
  logic                       srst = 1'b1;
  dbg_sel_pkg::scan_pins_type scan_in;
  dbg_sel_pkg::swd_pins_type  swd_in = 2'b00;
  logic                       reset_n_pin;
  logic                       tdo, tdo_oe, scan_mode, swd_enable, chip_in_reset;
  logic                       swdclk_core, swdio_core;
  logic [2:0]                 bp_count;
  logic [1:0]                 wp_count;
  logic [31:0]                got;
  logic [7:0]                 pin_in = 8'hA5;
  logic [7:0]                 core_out = 8'h3C;
  logic [7:0]                 pin_out, pin_oe_scan;
  int                         miscompares = 0;
  int                         n_tests = 0;
  row_type rows [4] = '{8'b0_11_101_00, 8'b1_11_010_11, 8'b1_10_010_10, 8'b0_01_101_00};
  always #2 clk = ~clk;
  dbg_sel dut (.clk(clk), .srst(srst), .reset_n_pin(reset_n_pin), .scan_in(scan_in),
    .swd_in(swd_in), .pin_in(pin_in), .core_out(core_out), .tdo(tdo), .tdo_oe(tdo_oe),
    .scan_mode(scan_mode), .swd_enable(swd_enable), .chip_in_reset(chip_in_reset),
    .pin_out(pin_out), .pin_oe_scan(pin_oe_scan),
    .swdclk_core(swdclk_core), .swdio_core(swdio_core),
    .bp_count(bp_count), .wp_count(wp_count));
  scan_tester tester (.clk(clk), .tdo(tdo), .pins(scan_in), .reset_n(reset_n_pin));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #300_000;
    miscompares++;
    give_verdict();
  end
  initial begin
    tester.wait_clk(16);
    srst = 1'b0;
    tester.power_up();
    foreach (rows[i]) begin
      swd_in = rows[i].swd;
      core_out = {4{rows[i].swd}};
      tester.set_pins(rows[i].pin, 1'b1);
      check("core pins", 32'({pin_oe_scan, pin_out}), 32'(core_out));
      check("mode", 32'({scan_mode, swd_enable, chip_in_reset}), 32'(rows[i].mode));
      check("swd core", 32'({swdclk_core, swdio_core}), 32'(rows[i].core));
      check("caps", 32'({bp_count, wp_count}), 32'({3'(dbg_sel_pkg::BREAKPOINTS),
        2'(dbg_sel_pkg::WATCHPOINTS)}));
      $display("test row %0d done", i);
    end
    tester.shift(32'h0B06, 32'h0040, 14, got);
    tester.wait_clk(10);
    check("scan out on", 32'(tdo_oe), 32'h1);
    tester.shift(32'h8000_0000, 32'h0, 32, got);
    check("identity", got, dbg_sel_pkg::ID_CODE);
    tester.shift(32'h1, 32'h0, 2, got);
    $display("test identity done");
    tester.shift(32'h0183, 32'h0, 10, got);
    tester.shift(32'h0C01, 32'h0348, 13, got);
    tester.wait_clk(10);
    check("captured pins", 32'(got[10:3]), 32'(pin_in));
    check("scan drive", 32'({pin_oe_scan, pin_out}), 32'h0000_FF69);
    $display("test extest done");
    tester.set_pins(1'b0, 1'b0);
    tester.shift(32'h0B06, 32'h0, 14, got);
    tester.wait_clk(10);
    check("scan out held", 32'(tdo_oe), 32'h0);
    check("pins held", 32'(pin_oe_scan), 32'h0);
    tester.set_pins(1'b1, 1'b0);
    check("debug back", 32'(swd_enable), 32'h1);
    tester.set_pins(1'b1, 1'b1);
    tester.shift(32'h0B06, 32'h0, 14, got);
    tester.wait_clk(10);
    check("no scan in debug", 32'(tdo_oe), 32'h0);
    $display("test exit done");
    srst = 1'b1;
    tester.wait_clk(2);
    check("mode in srst", 32'({scan_mode, swd_enable, chip_in_reset}), 32'h1);
    srst = 1'b0;
    tester.wait_clk(6);
    check("mode after srst", 32'({scan_mode, swd_enable, chip_in_reset}), 32'h2);
    $display("test srst done");
    give_verdict();
  end
endmodule
`default_nettype wire
